// >>> logic/rspm_top.sv
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/10ps
module rspm_top (
  input wire logic sys_clk_i,                      // System clock, 100 MHz
  input wire logic rst_n_i,                        // Synchronous reset, active low
  input wire logic [rspm_pkg::ADDR_W-1:0] reg_addr_i, // Register word index
  input wire logic [rspm_pkg::DATA_W-1:0] reg_wdata_i, // Register write data
  input wire logic reg_wr_i,                       // Write strobe
  input wire logic reg_rd_i,                       // Read strobe
  output logic [rspm_pkg::DATA_W-1:0] reg_rdata_o, // Read data, cycle after strobe
  input wire logic external_decoder_select_i,      // Strap: 1 selects outside decoder
  input wire logic bus_master_i,                   // Device owns the system bus
  input wire logic rx_line_i,                      // Manchester line into the codec
  input wire logic rx_clock_internal_i,            // Clock recovered by manchester_codec
  input wire logic rx_data_internal_i,             // NRZ data from manchester_codec
  input wire logic rx_data_pin_i,                  // Data pin level
  output logic rx_data_pin_o,                      // Data pin drive value
  output logic rx_data_pin_oe_o,                   // Data pin driven
  input wire logic rx_clock_pin_i,                 // Clock pin level
  output logic rx_clock_pin_o,                     // Clock pin drive value
  output logic rx_clock_pin_oe_o,                  // Clock pin driven
  output logic carrier_sense_out_o,                // Carrier sense
  output logic [rspm_pkg::BYTE_W-1:0] mac_data_o,  // Received byte to MAC
  output logic mac_valid_o,                        // Byte present
  input wire logic mac_ready_i                     // MAC takes the byte
);
  import rspm_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] sync_raw;
  logic [SYNC_W-1:0] sync_meta;
  logic [SYNC_W-1:0] sync_q;
  logic [SYNC_W-1:0] sync_prev;
  assign sync_raw = {external_decoder_select_i, rx_line_i, rx_clock_internal_i,
                     rx_data_internal_i, rx_clock_pin_i, rx_data_pin_i};

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      sync_meta <= SYNC_RESET;
      sync_q <= SYNC_RESET;
      sync_prev <= SYNC_RESET;
    end else begin
      sync_meta <= sync_raw;
      sync_q <= sync_meta;
      sync_prev <= sync_q;
    end
  end

  logic strap;
  logic line_now;
  logic line_was;
  logic rec_clk;
  logic rec_clk_was;
  logic data_int;
  logic pin_clk;
  logic pin_clk_was;
  logic pin_data;
  assign strap = sync_q[5];
  assign line_now = sync_q[4];
  assign line_was = sync_prev[4];
  assign rec_clk = sync_q[3];
  assign rec_clk_was = sync_prev[3];
  assign data_int = sync_q[2];
  assign pin_clk = sync_q[1];
  assign pin_clk_was = sync_prev[1];
  assign pin_data = sync_q[0];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] config_reg;
  logic [DATA_W-1:0] config_2_reg;
  logic configured;
  logic overrun;
  logic ext_bus;
  logic carrier;
  logic clock_run;
  logic wr_cfg;
  logic wr_cfg2;
  logic wr_status;
  logic set_overrun;
  assign wr_cfg = reg_wr_i && (reg_addr_i == ADDR_CONFIG);
  assign wr_cfg2 = reg_wr_i && (reg_addr_i == ADDR_CONFIG_2);
  assign wr_status = reg_wr_i && (reg_addr_i == ADDR_STATUS);
  assign ext_bus = config_reg[CFG_EXT_BUS_BIT];

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      config_reg <= CONFIG_RESET;
      config_2_reg <= CONFIG_2_RESET;
    end else begin
      if (wr_cfg) begin
        config_reg <= reg_wdata_i;
      end
      if (wr_cfg2) begin
        config_2_reg <= reg_wdata_i;
      end
    end
  end

  // Pins stay released until the first config write, whatever its value
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      configured <= 1'b0;
    end else if (wr_cfg) begin
      configured <= 1'b1; // R1
    end
  end

  // Sticky overrun: a new loss in the clearing cycle keeps the flag set
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      overrun <= 1'b0;
    end else if (set_overrun) begin
      overrun <= 1'b1;
    end else if (wr_status && reg_wdata_i[ST_OVERRUN_BIT]) begin
      overrun <= 1'b0;
    end
  end

  logic [DATA_W-1:0] status_word;
  always_comb begin
    status_word = '0;
    status_word[ST_CARRIER_BIT] = carrier;
    status_word[ST_STRAP_BIT] = strap;
    status_word[ST_CONFIGURED_BIT] = configured;
    status_word[ST_OVERRUN_BIT] = overrun;
    status_word[ST_CLOCK_RUN_BIT] = clock_run;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        ADDR_CONFIG: reg_rdata_o <= config_reg;
        ADDR_CONFIG_2: reg_rdata_o <= config_2_reg;
        ADDR_STATUS: reg_rdata_o <= status_word;
        default: reg_rdata_o <= '0;
      endcase
    end else begin
      reg_rdata_o <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Carrier sense and recovered clock run time
  // ----------------------------------------------------------------
  logic line_edge;
  logic line_fall;
  logic [CNT_W-1:0] carrier_cnt;
  logic [CNT_W-1:0] extend_cnt;
  assign line_edge = line_now != line_was;
  assign line_fall = line_was && !line_now;

  // Any line transition retriggers the hold; only a falling one may start it
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      carrier <= 1'b0;
      carrier_cnt <= '0;
    end else if ((carrier && line_edge) || (!carrier && line_fall)) begin
      carrier <= 1'b1; // R8
      carrier_cnt <= CNT_W'(CARRIER_HOLD_CYC);
    end else if (carrier_cnt > CNT_W'(1)) begin
      carrier_cnt <= carrier_cnt - 1'b1;
    end else begin
      carrier_cnt <= '0;
      carrier <= 1'b0; // R8
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      extend_cnt <= '0;
    end else if (carrier) begin
      extend_cnt <= CNT_W'(CLOCK_EXTEND_CYC); // R6
    end else if (extend_cnt != '0) begin
      extend_cnt <= extend_cnt - 1'b1;
    end
  end
  assign clock_run = carrier || (extend_cnt != '0);

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      carrier_sense_out_o <= 1'b0;
    end else begin
      carrier_sense_out_o <= carrier;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  // Data and clock leave through the same flop depth, so the data edge
  // stays a full half bit clear of the rising clock edge seen outside
  logic gated_clk;
  assign gated_clk = rec_clk && clock_run;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rx_data_pin_o <= 1'b0;
      rx_data_pin_oe_o <= 1'b0;
    end else if (!configured) begin
      rx_data_pin_o <= 1'b0;
      rx_data_pin_oe_o <= 1'b0; // R1
    end else if (ext_bus) begin
      rx_data_pin_o <= config_2_reg[CFG2_USER0_BIT]; // R5
      rx_data_pin_oe_o <= bus_master_i; // R5
    end else if (!strap) begin
      rx_data_pin_o <= data_int; // R2
      rx_data_pin_oe_o <= 1'b1; // R2
    end else begin
      rx_data_pin_o <= 1'b0;
      rx_data_pin_oe_o <= 1'b0; // R4
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rx_clock_pin_o <= 1'b0;
      rx_clock_pin_oe_o <= 1'b0;
    end else if (!configured) begin
      rx_clock_pin_o <= 1'b0;
      rx_clock_pin_oe_o <= 1'b0; // R1
    end else if (ext_bus) begin
      rx_clock_pin_o <= config_2_reg[CFG2_USER1_BIT];
      rx_clock_pin_oe_o <= bus_master_i;
    end else if (!strap) begin
      rx_clock_pin_o <= gated_clk; // R6
      rx_clock_pin_oe_o <= 1'b1; // R6
    end else begin
      rx_clock_pin_o <= 1'b0;
      rx_clock_pin_oe_o <= 1'b0; // R7
    end
  end

  // ----------------------------------------------------------------
  // MAC capture: one bit per rising edge of the selected clock
  // ----------------------------------------------------------------
  logic cap_strobe;
  logic cap_bit;
  logic [BYTE_W-1:0] shift;
  logic [2:0] bit_cnt;
  logic byte_valid;
  logic [BYTE_W-1:0] byte_data;
  logic fifo_in_ready;
  // With the extended bus the data pin is an output and carries no frame
  assign cap_strobe = strap ? (!ext_bus && pin_clk && !pin_clk_was) // R4
                            : (clock_run && rec_clk && !rec_clk_was); // R2
  assign cap_bit = strap ? pin_data : data_int;

  // First bit on the wire lands in bit 0; a new internal-decoder frame restarts alignment
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      shift <= '0;
      bit_cnt <= '0;
      byte_valid <= 1'b0;
      byte_data <= '0;
    end else begin
      byte_valid <= 1'b0;
      if (cap_strobe) begin
        shift <= {cap_bit, shift[BYTE_W-1:1]};
        bit_cnt <= bit_cnt + 1'b1;
        if (bit_cnt == 3'h7) begin
          byte_data <= {cap_bit, shift[BYTE_W-1:1]};
          byte_valid <= 1'b1;
        end
      end else if (!strap && !clock_run) begin
        bit_cnt <= '0;
      end
    end
  end

  // The serial stream cannot be paused, so a full buffer loses the byte
  assign set_overrun = byte_valid && !fifo_in_ready;

  logic [BYTE_W-1:0] fifo_data;
  logic fifo_valid;
  logic fifo_take;
  assign fifo_take = !mac_valid_o || mac_ready_i;

  rspm_fifo #(
    .WIDTH(BYTE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .in_data_i(byte_data),
    .in_valid_i(byte_valid),
    .in_ready_o(fifo_in_ready),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_take)
  );

  // Output stage keeps the MAC outputs straight off flops
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      mac_data_o <= '0;
      mac_valid_o <= 1'b0;
    end else if (fifo_take) begin
      mac_data_o <= fifo_data;
      mac_valid_o <= fifo_valid;
    end
  end
endmodule : rspm_top

// >>> logic/rspm_pkg.sv
// What this block does
// R1 - Data and clock pins float until software writes the data config register.
// R2 - Strap at 0: internal decoder data goes to the MAC and the data pin.
// R3 - Outside observer samples the data pin on rising edges of the clock pin.
// R4 - Strap at 1: MAC takes pin data on each rising edge of the clock pin. The code takes nothing while the extended bus bit is set.
// R5 - Extended bus: data pin is user output 0, driven only while bus master.
// R6 - Internal recovered clock reaches MAC and pin, runs 5 bits past carrier.
// R7 - External decoder supplies its recovered clock on the clock pin.
// R8 - Carrier sense rises on first falling line edge, holds 1.5 bits past data.
package rspm_pkg;
  // ----------------------------------------------------------------
  // Register map (word index on the register port)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 2;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] ADDR_CONFIG = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_CONFIG_2 = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 2'h2;
  localparam logic [DATA_W-1:0] CONFIG_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] CONFIG_2_RESET = 16'h0000;
  // Field positions
  localparam int CFG_EXT_BUS_BIT = 15;
  localparam int CFG2_USER0_BIT = 0;
  localparam int CFG2_USER1_BIT = 1;
  localparam int ST_CARRIER_BIT = 0;
  localparam int ST_STRAP_BIT = 1;
  localparam int ST_CONFIGURED_BIT = 2;
  localparam int ST_OVERRUN_BIT = 3;
  localparam int ST_CLOCK_RUN_BIT = 4;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int BIT_TIME_NS = 100;
  localparam int CARRIER_HOLD_TENTH_BITS = 15;
  localparam int CLOCK_EXTEND_BITS = 5;
  localparam int CARRIER_HOLD_NS = CARRIER_HOLD_TENTH_BITS * BIT_TIME_NS / 10;
  localparam int CARRIER_HOLD_CYC = (CARRIER_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLOCK_EXTEND_NS = CLOCK_EXTEND_BITS * BIT_TIME_NS;
  localparam int CLOCK_EXTEND_CYC = (CLOCK_EXTEND_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
  // ----------------------------------------------------------------
  // Data path
  // ----------------------------------------------------------------
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 4;
  localparam int SYNC_W = 6;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 6'h00;
endpackage : rspm_pkg

// >>> logic/rspm_fifo.sv
`timescale 1ns/10ps
module rspm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic sys_clk_i,           // System clock
  input wire logic rst_n_i,             // Synchronous reset, active low
  input wire logic [WIDTH-1:0] in_data_i, // Word to store
  input wire logic in_valid_i,          // Word offered
  output logic in_ready_o,              // Room for a word
  output logic [WIDTH-1:0] out_data_o,  // Oldest word
  output logic out_valid_o,             // Oldest word present
  input wire logic out_ready_i          // Drain side takes the word
);
  localparam int PTR_W = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0] count;
  logic do_push;
  logic do_pop;

  assign in_ready_o = (count != (PTR_W+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];
  assign do_push = in_valid_i && in_ready_o;
  assign do_pop = out_valid_o && out_ready_i;

  always_ff @(posedge sys_clk_i) begin
    if (do_push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= (wr_ptr == PTR_W'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= (rd_ptr == PTR_W'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (PTR_W+1)'(do_push) - (PTR_W+1)'(do_pop);
    end
  end
endmodule : rspm_fifo

// >>> tb/rspm_properties.sv
`timescale 1ns/10ps
module rspm_properties (
  input wire logic sys_clk_i, // Clock
  input wire logic rst_n_i, // Reset
  input wire logic [rspm_pkg::ADDR_W-1:0] reg_addr_i, // Index
  input wire logic [rspm_pkg::DATA_W-1:0] reg_wdata_i, // Write data
  input wire logic reg_wr_i, // Write
  input wire logic reg_rd_i, // Read
  input wire logic [rspm_pkg::DATA_W-1:0] reg_rdata_o, // Read data
  input wire logic external_decoder_select_i, // Strap
  input wire logic bus_master_i, // Bus owner
  input wire logic rx_line_i, // Line
  input wire logic rx_clock_internal_i, // Codec clock
  input wire logic rx_data_internal_i, // Codec data
  input wire logic rx_data_pin_o, // Data drive
  input wire logic rx_data_pin_oe_o, // Data enable
  input wire logic rx_clock_pin_o, // Clock drive
  input wire logic rx_clock_pin_oe_o, // Clock enable
  input wire logic carrier_sense_out_o // Carrier
);
  import rspm_pkg::*;
  logic cfg;
  logic external_decoder_select;
  logic [7:0] quiet;
  logic [7:0] since_cs;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // ----------------------------------------------------------------
  // Mode tracking and activity ages
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cfg <= 1'b0;
      external_decoder_select <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == ADDR_CONFIG) begin
      cfg <= 1'b1;
      external_decoder_select <= reg_wdata_i[CFG_EXT_BUS_BIT];
    end
  end
  // Saturating, so a long idle line never wraps into a false short age
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || rx_line_i != $past(rx_line_i)) begin
      quiet <= 8'h00;
    end else if (quiet != 8'hff) begin
      quiet <= quiet + 8'h01;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || carrier_sense_out_o) begin
      since_cs <= 8'h00;
    end else if (since_cs != 8'hff) begin
      since_cs <= since_cs + 8'h01;
    end
  end
  chk_unconfig_float: assert property (
    !cfg |-> !rx_data_pin_oe_o && !rx_clock_pin_oe_o) else $error("pin driven before config");
  chk_internal_data_out: assert property (
    cfg && $past(cfg, 4) && !external_decoder_select && !external_decoder_select_i
    |-> rx_data_pin_oe_o && rx_data_pin_o == $past(rx_data_internal_i, 3))
    else $error("data pin not following codec data");
  chk_strap_input_float: assert property (
    cfg && !external_decoder_select && external_decoder_select_i |-> !rx_data_pin_oe_o && !rx_clock_pin_oe_o)
    else $error("pin driven in outside decoder mode");
  chk_user_out_enable: assert property (
    cfg && external_decoder_select && $past(external_decoder_select, 2)
    |-> rx_data_pin_oe_o == $past(bus_master_i) && rx_clock_pin_oe_o == $past(bus_master_i))
    else $error("user output enable not bus master");
  chk_clock_out_run: assert property (
    cfg && $past(cfg, 4) && !external_decoder_select && !external_decoder_select_i
    && (carrier_sense_out_o && $past(carrier_sense_out_o, 2)
    || since_cs >= 8'h02 && since_cs <= 8'h2d)
    |-> rx_clock_pin_oe_o && rx_clock_pin_o == $past(rx_clock_internal_i, 3))
    else $error("clock pin not following recovered clock");
  chk_carrier_start: assert property (
    $fell(rx_line_i) |-> ##[1:5] carrier_sense_out_o) else $error("carrier late");
  chk_carrier_hold: assert property (
    $fell(carrier_sense_out_o) |-> quiet >= 8'h0e && quiet <= 8'h16)
    else $error("carrier hold wrong");
  chk_rdata_idle: assert property (
    !$past(reg_rd_i) |-> reg_rdata_o == 16'h0000) else $error("read data outside slot");
endmodule : rspm_properties

bind rspm_top rspm_properties chk (.*);

// >>> tb/rspm_far_end.sv
`timescale 1ns/10ps
module rspm_far_end (
  output logic line_o, // Manchester line
  output logic clk_int_o, // Codec recovered clock
  output logic data_int_o, // Codec NRZ data
  output logic clk_pin_o, // Outside decoder clock
  output logic data_pin_o // Outside decoder data
);
  initial begin
    line_o = 1'b1;
    clk_int_o = 1'b0;
    data_int_o = 1'b0;
    clk_pin_o = 1'b0;
    data_pin_o = 1'b0;
  end
  // ----------------------------------------------------------------
  // One byte, first bit first, 160 ns clock; tail bits carry a toggling pattern
  // ----------------------------------------------------------------
  task automatic send(input logic [7:0] b, input logic external_decoder_select, input int tail);
    logic d;
    // Stay 2 ns off the system edges so no input moves on a sampling edge
    #2;
    for (int i = 0; i < 8 + tail; i++) begin
      d = (i < 8) ? b[i] : ~d;
      // Data moves on the falling clock edge so rising-edge capture is safe
      if (external_decoder_select) data_pin_o = d;
      else data_int_o = d;
      if (!external_decoder_select && i < 8) line_o = ~line_o;
      #80;
      if (external_decoder_select) clk_pin_o = 1'b1;
      else clk_int_o = 1'b1;
      if (!external_decoder_select && i < 8) line_o = ~line_o;
      #80;
      if (external_decoder_select) clk_pin_o = 1'b0;
      else clk_int_o = 1'b0;
    end
    // Released lines show the inverse, never the stale bit
    data_pin_o = ~data_pin_o;
    data_int_o = ~data_int_o;
    // Return on a system edge again, so back-to-back bytes keep the offset
    #8;
  endtask : send
endmodule : rspm_far_end

// >>> tb/rx_serial_pin_mux_bench.sv
`timescale 1ns/10ps
module rx_serial_pin_mux_bench;
  import rspm_pkg::*;
  logic sys_clk_i, rst_n_i, reg_wr_i, reg_rd_i, strap, bus_master, mac_ready_i, mac_valid_o;
  logic [ADDR_W-1:0] reg_addr_i;
  logic [DATA_W-1:0] reg_wdata_i, reg_rdata_o;
  logic line, clk_int, data_int, clk_pin, data_pin, dpo, dpoe, cpo, cpoe, carrier, prev;
  logic [BYTE_W-1:0] mac_data_o;
  logic [7:0] tab [6] = '{8'h5a, 8'h81, 8'h0f, 8'hc3, 8'h7e, 8'h96};
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  int early, late;
  // Pin level follows the DUT's enable, otherwise the far end's drive
  wire logic dwire = dpoe ? dpo : data_pin;
  wire logic cwire = cpoe ? cpo : clk_pin;
  rspm_far_end far (.line_o(line), .clk_int_o(clk_int), .data_int_o(data_int),
    .clk_pin_o(clk_pin), .data_pin_o(data_pin));
  rspm_top dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .external_decoder_select_i(strap), .bus_master_i(bus_master),
    .rx_line_i(line), .rx_clock_internal_i(clk_int), .rx_data_internal_i(data_int),
    .rx_data_pin_i(dwire), .rx_data_pin_o(dpo), .rx_data_pin_oe_o(dpoe),
    .rx_clock_pin_i(cwire), .rx_clock_pin_o(cpo), .rx_clock_pin_oe_o(cpoe),
    .carrier_sense_out_o(carrier), .mac_data_o(mac_data_o), .mac_valid_o(mac_valid_o),
    .mac_ready_i(mac_ready_i));
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  // Clock-running flag is left out while the outside decoder is strapped
  task automatic rd(input logic [1:0] a, input logic [15:0] e);
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    @(posedge sys_clk_i);
    chk(reg_rdata_o & (strap ? 16'hffef : 16'hffff), e);
  endtask : rd
  task automatic take(input logic [7:0] e);
    int n = 0;
    do @(posedge sys_clk_i); while (mac_valid_o !== 1'b1 && ++n < 300);
    chk({8'h00, mac_data_o}, {8'h00, e});
    mac_ready_i <= 1'b1;
    @(posedge sys_clk_i);
    mac_ready_i <= 1'b0;
  endtask : take
  task automatic restart(input logic s);
    rst_n_i <= 1'b0;
    strap <= s;
    bus_master <= 1'b0;
    repeat (5) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
  endtask : restart
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    rst_n_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 2'h0;
    reg_wdata_i = 16'h0000;
    mac_ready_i = 1'b0;
    restart(1'b1);
    chk({14'h0000, dpoe, cpoe}, 16'h0000);
    rd(ADDR_STATUS, 16'h0002);
    wr(ADDR_CONFIG, 16'h0000);
    rd(ADDR_STATUS, 16'h0006);
    // Output stage plus four buffered words hold five bytes; the sixth overruns
    for (int i = 0; i < 6; i++) far.send(tab[i], 1'b1, 0);
    chk({14'h0000, dpoe, cpoe}, 16'h0000);
    rd(ADDR_STATUS, 16'h000e);
    wr(ADDR_STATUS, 16'h0008);
    rd(ADDR_STATUS, 16'h0006);
    for (int i = 0; i < 5; i++) take(tab[i]);
    @(posedge sys_clk_i);
    chk({15'h0000, mac_valid_o}, 16'h0000);
    $display("outside decoder stream done");
    wr(ADDR_CONFIG_2, 16'h0003);
    wr(ADDR_CONFIG, 16'h8000);
    repeat (4) @(posedge sys_clk_i);
    chk({14'h0000, dpoe, cpoe}, 16'h0000);
    bus_master <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    chk({12'h000, dpoe, dpo, cpoe, cpo}, 16'h000f);
    wr(ADDR_CONFIG_2, 16'h0002);
    repeat (3) @(posedge sys_clk_i);
    chk({12'h000, dpoe, dpo, cpoe, cpo}, 16'h000b);
    rd(ADDR_CONFIG_2, 16'h0002);
    rd(2'h3, 16'h0000);
    bus_master <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    chk({14'h0000, dpoe, cpoe}, 16'h0000);
    $display("user output done");
    restart(1'b0);
    wr(ADDR_CONFIG, 16'h0000);
    fork
      far.send(8'ha5, 1'b0, 14);
    join_none
    repeat (40) @(posedge sys_clk_i);
    chk({13'h0000, carrier, dpoe, cpoe}, 16'h0007);
    rd(ADDR_STATUS, 16'h0015);
    take(8'ha5);
    early = 0;
    while (carrier !== 1'b0 && early < 500) begin
      @(posedge sys_clk_i);
      early++;
    end
    early = 0;
    late = 0;
    prev = cpo;
    for (int i = 0; i < 160; i++) begin
      @(posedge sys_clk_i);
      if (cpo !== prev && i < 40) early++;
      if (cpo !== prev && i >= 65) late++;
      prev = cpo;
    end
    chk({15'h0000, early != 0}, 16'h0001);
    chk({15'h0000, late != 0}, 16'h0000);
    rd(ADDR_STATUS, 16'h0004);
    wait fork;
    $display("internal decoder frame done");
    final_report();
  end
endmodule : rx_serial_pin_mux_bench
